/* src/fault_flag_pkg.sv */
// Constants, field positions and carrier types for the fault status flag bank.
// Assumes a byte-wide register port from the management bus logic on core_clk_i.
package fault_flag_pkg;

	// Register addresses on the management bus
	localparam logic [7:0] addr_oc_thermal   = 8'hd5;
	localparam logic [7:0] addr_serious_oc   = 8'hd6;
	localparam logic [7:0] addr_bus_limit    = 8'hd7;

	// Reset value shared by all flag registers
	localparam logic [7:0] flag_reset_value  = 8'h00;

	// Field positions
	localparam int thermal_bit               = 7;
	localparam int cont_oc2_bit              = 2;
	localparam int cont_noc_bit              = 4;
	localparam int lv_out_ov_bit             = 0;
	localparam int lv_out_uv_bit             = 1;
	localparam int lv_in_ov_bit              = 2;
	localparam int lv_in_uv_bit              = 3;
	localparam int hv_out_ov_bit             = 4;
	localparam int hv_out_uv_bit             = 5;
	localparam int hv_in_ov_bit              = 6;
	localparam int hv_in_uv_bit              = 7;

	// Writable masks; reserved bits never store
	localparam logic [7:0] oc_thermal_mask   = 8'h80;
	localparam logic [7:0] serious_oc_mask   = 8'h14;
	localparam logic [7:0] bus_limit_mask    = 8'hff;

	// Persistence: a condition must stand more than this many cycles
	localparam int          persist_cycles   = 3;
	localparam logic [2:0]  persist_limit    = 3'(persist_cycles + 1);

	// Voltage limit comparator results from the analog front end
	typedef struct packed {
		logic lv_ov;      // Low-voltage bus above protection limit
		logic lv_uv;      // Low-voltage bus below protection limit
		logic hv_ov;      // High-voltage bus above protection limit
		logic hv_uv;      // High-voltage bus below protection limit
	} bus_limit_t;

	// Register access strobe group
	typedef struct packed {
		logic       wr;   // One-cycle write strobe
		logic       rd;   // One-cycle read strobe
		logic [7:0] addr; // Register address
		logic [7:0] data; // Write data
	} reg_req_t;

endpackage : fault_flag_pkg

/* src/fault_status_flag_bank.sv */
// Fault status flag bank: thermal flag, serious overcurrent and bus limit flags.
// Assumes fault comparator inputs are asynchronous and that the management bus
// decoder presents one-cycle read/write strobes on core_clk_i.
`timescale 1ns/1ns
`default_nettype none
module fault_status_flag_bank
	import fault_flag_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       reset_n_i,
	// Analog comparator results (asynchronous)
	input  wire logic       over_temp_i,
	input  wire logic       second_level_overcurrent_i,
	input  wire logic       negative_overcurrent_i,
	input  wire logic       step_up_mode_i,
	input  wire bus_limit_t bus_limit_i,
	// Register port
	input  wire reg_req_t   reg_req_i,
	output logic [7:0]      rd_data_o,
	output logic            rd_valid_o,
	// Power stage control
	output logic            switch_off_o,
	// Flag images
	output logic [7:0]      oc_thermal_o,
	output logic [7:0]      serious_oc_o,
	output logic [7:0]      bus_limit_o
);

	// Two-stage synchronisers for all asynchronous inputs
	logic [7:0] sync_a;               // First stage, read only by second stage
	logic [7:0] sync_b;               // Second stage, used by logic
	logic       temp_s;               // Synced over-temperature
	logic       oc2_s;                // Synced second-level overcurrent
	logic       noc_s;                // Synced negative overcurrent
	logic       up_s;                 // Synced step-up mode
	bus_limit_t lim_s;                // Synced bus limits

	logic [2:0] oc2_run;              // Consecutive cycles of overcurrent
	logic [2:0] noc_run;              // Consecutive cycles of negative overcurrent
	logic [7:0] oc_thermal;           // Thermal flag register
	logic [7:0] serious_oc;           // Serious overcurrent register
	logic [7:0] bus_limit;            // Bus limit register
	logic [7:0] next_oc_set;          // Hardware set terms
	logic [7:0] next_sc_set;
	logic [7:0] next_bl_set;

	// Saturating run counter step
	function automatic logic [2:0] run_step(input logic level, input logic [2:0] cnt);
		if (!level) begin
			return 3'h0;
		end
		return (cnt == persist_limit) ? cnt : 3'(cnt + 3'h1);
	endfunction : run_step

	// Sticky update: set wins over a written clear, reserved bits stay zero
	function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set,
		input logic [7:0] mask, input logic wr, input logic [7:0] wdata);
		logic [7:0] kept;
		kept = wr ? (cur & wdata) : cur;
		return (kept | set) & mask;
	endfunction : sticky

	assign temp_s = sync_b[0];
	assign oc2_s  = sync_b[1];
	assign noc_s  = sync_b[2];
	assign up_s   = sync_b[3];
	assign lim_s  = bus_limit_t'(sync_b[7:4]);

	// Synchroniser flops
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			sync_a <= 8'h00;
			sync_b <= 8'h00;
		end else begin
			sync_a <= {bus_limit_i, step_up_mode_i, negative_overcurrent_i,
				second_level_overcurrent_i, over_temp_i};
			sync_b <= sync_a;
		end
	end

	// Persistence counters for the two shutdown faults
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			oc2_run <= 3'h0;
			noc_run <= 3'h0;
		end else begin
			oc2_run <= run_step(oc2_s, oc2_run);
			noc_run <= run_step(noc_s, noc_run);
		end
	end

	// Hardware set terms
	always_comb begin
		next_oc_set = 8'h00;
		next_sc_set = 8'h00;
		next_bl_set = 8'h00;
		next_oc_set[thermal_bit]   = temp_s;
		next_sc_set[cont_oc2_bit]  = (oc2_run == persist_limit);
		next_sc_set[cont_noc_bit]  = (noc_run == persist_limit);
		next_bl_set[lv_out_ov_bit] = !up_s && lim_s.lv_ov;
		next_bl_set[lv_out_uv_bit] = !up_s && lim_s.lv_uv;
		next_bl_set[lv_in_ov_bit]  =  up_s && lim_s.lv_ov;
		next_bl_set[lv_in_uv_bit]  =  up_s && lim_s.lv_uv;
		next_bl_set[hv_out_ov_bit] =  up_s && lim_s.hv_ov;
		next_bl_set[hv_out_uv_bit] =  up_s && lim_s.hv_uv;
		next_bl_set[hv_in_ov_bit]  = !up_s && lim_s.hv_ov;
		next_bl_set[hv_in_uv_bit]  = !up_s && lim_s.hv_uv;
	end

	// Flag registers: sticky until written zero
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			oc_thermal <= flag_reset_value;
			serious_oc <= flag_reset_value;
			bus_limit  <= flag_reset_value;
		end else begin
			oc_thermal <= sticky(oc_thermal, next_oc_set, oc_thermal_mask,
				reg_req_i.wr && reg_req_i.addr == addr_oc_thermal, reg_req_i.data);
			serious_oc <= sticky(serious_oc, next_sc_set, serious_oc_mask,
				reg_req_i.wr && reg_req_i.addr == addr_serious_oc, reg_req_i.data);
			bus_limit  <= sticky(bus_limit, next_bl_set, bus_limit_mask,
				reg_req_i.wr && reg_req_i.addr == addr_bus_limit, reg_req_i.data);
		end
	end

	// Switch shutdown follows the serious overcurrent flags
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			switch_off_o <= 1'b0;
		end else begin
			switch_off_o <= (|next_sc_set) || (|serious_oc);
		end
	end

	// Read path, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			rd_data_o  <= 8'h00;
			rd_valid_o <= 1'b0;
		end else begin
			rd_valid_o <= reg_req_i.rd;
			unique case (reg_req_i.addr)
				addr_oc_thermal: rd_data_o <= reg_req_i.rd ? oc_thermal : 8'h00;
				addr_serious_oc: rd_data_o <= reg_req_i.rd ? serious_oc : 8'h00;
				addr_bus_limit:  rd_data_o <= reg_req_i.rd ? bus_limit : 8'h00;
				default:         rd_data_o <= 8'h00;
			endcase
		end
	end

	// Flag images
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			oc_thermal_o <= 8'h00;
			serious_oc_o <= 8'h00;
			bus_limit_o  <= 8'h00;
		end else begin
			oc_thermal_o <= oc_thermal;
			serious_oc_o <= serious_oc;
			bus_limit_o  <= bus_limit;
		end
	end

	// Assertions

	// Fault runs: four synced highs trip, three after a low do not
	sequence s_oc2_held;
		oc2_s [*4];
	endsequence
	sequence s_noc_held;
		noc_s [*4];
	endsequence
	sequence s_oc2_short;
		!oc2_s ##1 oc2_s [*3];
	endsequence
	sequence s_noc_short;
		!noc_s ##1 noc_s [*3];
	endsequence

	// Thermal flag follows the synced input one edge later
	a_thermal_set: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		temp_s |=> oc_thermal[thermal_bit])
		else $error("thermal flag not set");
	// Counter reaches its limit one edge after the run, flag one more
	a_oc2_persist: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_oc2_held |-> ##2 serious_oc[cont_oc2_bit])
		else $error("continuous overcurrent flag missing");
	// A run of three cycles leaves the flag alone
	a_oc2_early: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_oc2_short |=> (serious_oc[cont_oc2_bit] == $past(serious_oc[cont_oc2_bit])))
		else $error("overcurrent flagged too early");
	// Flag and shut-off land on the same edge
	a_noc_persist: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_noc_held |-> ##2 (serious_oc[cont_noc_bit] && switch_off_o))
		else $error("negative overcurrent shutdown missing");

	// A short negative run leaves its flag alone
	a_noc_early: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		s_noc_short |=> (serious_oc[cont_noc_bit] == $past(serious_oc[cont_noc_bit])))
		else $error("negative overcurrent flagged too early");

	// A single low cycle restarts the persistence count
	a_oc2_restart: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		!oc2_s |=> (oc2_run == 3'h0))
		else $error("overcurrent run not restarted");

	// Any stored serious flag keeps the switches off
	a_switch_hold: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(|serious_oc) |=> switch_off_o)
		else $error("switches released while a serious flag stands");

	// With no serious flag and no set term the switches run
	a_switch_idle: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		((serious_oc == 8'h00) && (next_sc_set == 8'h00)) |=> !switch_off_o)
		else $error("switches off without a serious flag");

	// Thermal flag stays clear in the normal range
	a_thermal_quiet: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(!temp_s && !oc_thermal[thermal_bit]) |=> !oc_thermal[thermal_bit])
		else $error("thermal flag set in normal range");

	// A clear written while the fault stands loses to the set
	a_set_wins: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(reg_req_i.wr && reg_req_i.addr == addr_oc_thermal && temp_s) |=> oc_thermal[thermal_bit])
		else $error("clear beat a standing thermal fault");

	// Mode bits chosen by the current direction
	a_down_lv_ov: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(!up_s && lim_s.lv_ov) |=> bus_limit[lv_out_ov_bit])
		else $error("low bus output overvoltage missed");
	a_down_lv_uv: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(!up_s && lim_s.lv_uv) |=> bus_limit[lv_out_uv_bit])
		else $error("low bus output undervoltage missed");
	a_up_lv_ov: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(up_s && lim_s.lv_ov) |=> bus_limit[lv_in_ov_bit])
		else $error("low bus input overvoltage missed");
	a_up_lv_uv: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(up_s && lim_s.lv_uv) |=> bus_limit[lv_in_uv_bit])
		else $error("low bus input undervoltage missed");
	a_up_hv_ov: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(up_s && lim_s.hv_ov) |=> bus_limit[hv_out_ov_bit])
		else $error("high bus output overvoltage missed");
	a_up_hv_uv: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(up_s && lim_s.hv_uv) |=> bus_limit[hv_out_uv_bit])
		else $error("high bus output undervoltage missed");
	a_down_hv_ov: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(!up_s && lim_s.hv_ov) |=> bus_limit[hv_in_ov_bit])
		else $error("high bus input overvoltage missed");
	a_down_hv_uv: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(!up_s && lim_s.hv_uv) |=> bus_limit[hv_in_uv_bit])
		else $error("high bus input undervoltage missed");

	// A written zero clears only when no set term stands
	a_bl_clear: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(reg_req_i.wr && reg_req_i.addr == addr_bus_limit && next_bl_set == 8'h00)
		|=> (bus_limit == ($past(bus_limit) & $past(reg_req_i.data))))
		else $error("bus limit clear wrong");

	// Writing ones never raises a serious flag
	a_sc_clear: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(reg_req_i.wr && reg_req_i.addr == addr_serious_oc && next_sc_set == 8'h00)
		|=> (serious_oc == ($past(serious_oc) & $past(reg_req_i.data) & serious_oc_mask)))
		else $error("serious overcurrent write wrong");

	// Read answer comes exactly one cycle after the strobe
	a_read_valid: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		reg_req_i.rd |=> rd_valid_o)
		else $error("read answer missing");

	// No answer without a strobe
	a_valid_pulse: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		!reg_req_i.rd |=> !rd_valid_o)
		else $error("read answer without strobe");

	// Unmapped addresses read zero
	a_read_unmapped: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(reg_req_i.rd && reg_req_i.addr != addr_oc_thermal && reg_req_i.addr != addr_serious_oc
		&& reg_req_i.addr != addr_bus_limit) |=> (rd_data_o == 8'h00))
		else $error("unmapped read not zero");

	// Thermal register read returns the stored flag
	a_read_oc: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(reg_req_i.rd && reg_req_i.addr == addr_oc_thermal) |=> (rd_data_o == $past(oc_thermal)))
		else $error("thermal register read wrong");

	// Serious overcurrent read returns the stored flags
	a_read_sc: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(reg_req_i.rd && reg_req_i.addr == addr_serious_oc) |=> (rd_data_o == $past(serious_oc)))
		else $error("serious overcurrent read wrong");

	// Bus limit read returns the stored flags
	a_read_bl: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(reg_req_i.rd && reg_req_i.addr == addr_bus_limit) |=> (rd_data_o == $past(bus_limit)))
		else $error("bus limit read wrong");

	// Images trail the registers by one edge
	a_image_copy: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		1'b1 |=> ((oc_thermal_o == $past(oc_thermal)) && (serious_oc_o == $past(serious_oc))
		&& (bus_limit_o == $past(bus_limit))))
		else $error("flag image out of step");

	// Stored bus limit bit 0 survives until written
	a_flag_sticky: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		(bus_limit[0] && !(reg_req_i.wr && reg_req_i.addr == addr_bus_limit)) |=> bus_limit[0])
		else $error("flag dropped without a write");
	a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		((serious_oc & ~serious_oc_mask) == 8'h00) && ((oc_thermal & ~oc_thermal_mask) == 8'h00))
		else $error("reserved bit set");

endmodule : fault_status_flag_bank
`default_nettype wire

/* verification/mcu_model.sv */
// System controller model: issues one-cycle register strobes to the flag bank.
// Assumes the bank answers a read exactly one cycle after the strobe edge.
`timescale 1ns/1ns
`default_nettype none
module mcu_model
	import fault_flag_pkg::*;
(
	// Clock
	input  wire logic       core_clk_i,
	// Register port
	output var  reg_req_t   reg_req_o,
	input  wire logic [7:0] rd_data_i,
	input  wire logic       rd_valid_i
);
	// Idle bus at time zero
	initial reg_req_o = '0;

	// One strobe held for one edge; read data taken at the edge closing its cycle
	// No control settings exist here, so a clear never precedes a reload
	task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
		output logic [7:0] rdata);
		@(posedge core_clk_i);
		reg_req_o <= '{wr: wr, rd: !wr, addr: addr, data: data};
		@(posedge core_clk_i);
		reg_req_o <= '0;
		@(posedge core_clk_i);
		rdata = rd_valid_i ? rd_data_i : 8'hxx;
	endtask : access
endmodule : mcu_model
`default_nettype wire

/* verification/fault_status_flag_bank_tb.sv */
// Testbench for the fault flag bank: raises faults, reads and clears flags.
// Assumes the bank needs three cycles from a fault input to its flag, seven for the persistence faults.
`timescale 1ns/1ns
`default_nettype none
module fault_status_flag_bank_tb;
	import fault_flag_pkg::*;
	logic       core_clk_i = 1'b0; // 50 MHz clock
	logic       reset_n_i  = 1'b0; // Synchronous reset, active low
	logic       step_up    = 1'b0; // Converter direction
	logic [6:0] f          = '0;   // {thermal, oc2, noc, bus limit}
	reg_req_t   req;               // Strobes from the controller model
	logic [7:0] rd_data;           // Read data
	logic [7:0] r;                 // Last read value
	logic       rd_valid;          // Read answer strobe
	logic       sw_off;            // Switch shut-off
	logic [7:0] img_oc;            // Thermal register image
	logic [7:0] img_sc;            // Serious overcurrent image
	logic [7:0] img_bl;            // Bus limit image
	int         failures = 0;      // Mismatches
	int         n_tests  = 0;      // Comparisons
	int         bit_of [2][4] = '{'{lv_out_ov_bit, lv_out_uv_bit, hv_in_ov_bit, hv_in_uv_bit},
		'{lv_in_ov_bit, lv_in_uv_bit, hv_out_ov_bit, hv_out_uv_bit}};

	// Clock generator
	always #10 core_clk_i = ~core_clk_i;

	mcu_model mcu (.core_clk_i(core_clk_i), .reg_req_o(req), .rd_data_i(rd_data),
		.rd_valid_i(rd_valid));

	fault_status_flag_bank uut (
		.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .over_temp_i(f[6]),
		.second_level_overcurrent_i(f[5]), .negative_overcurrent_i(f[4]),
		.step_up_mode_i(step_up), .bus_limit_i(bus_limit_t'(f[3:0])), .reg_req_i(req),
		.rd_data_o(rd_data), .rd_valid_o(rd_valid), .switch_off_o(sw_off),
		.oc_thermal_o(img_oc), .serious_oc_o(img_sc), .bus_limit_o(img_bl));

	// Compare and count
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Read a register and compare
	task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
		mcu.access(1'b0, a, 8'h00, r);
		check("rd_data_o", r, exp);
	endtask : expect_reg

	// Hold a fault pattern for n edges, then let the synchronisers drain
	task automatic hold(input logic [6:0] v, input int n);
		@(posedge core_clk_i);
		f <= v;
		repeat (n) @(posedge core_clk_i);
		f <= '0;
		repeat (6) @(posedge core_clk_i);
	endtask : hold

	// Verdict and end of run
	task automatic results();
		if (failures == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results

	// Watchdog
	initial begin
		#200us;
		failures++;
		results();
	end

	// Test sequence
	initial begin
		repeat (16) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		expect_reg(addr_serious_oc, flag_reset_value);
		expect_reg(addr_bus_limit, flag_reset_value);
		expect_reg(addr_oc_thermal, 8'h00);
		hold(7'h40, 4);
		expect_reg(addr_oc_thermal, 8'h80);
		check("oc_thermal_o", img_oc, 8'h80);
		mcu.access(1'b1, addr_oc_thermal, 8'h00, r);
		expect_reg(addr_oc_thermal, 8'h00);
		// A clear written while the fault still stands loses to the set
		@(posedge core_clk_i);
		f <= 7'h40;
		repeat (4) @(posedge core_clk_i);
		mcu.access(1'b1, addr_oc_thermal, 8'h00, r);
		expect_reg(addr_oc_thermal, 8'h80);
		f <= '0;
		repeat (6) @(posedge core_clk_i);
		mcu.access(1'b1, addr_oc_thermal, 8'h00, r);
		expect_reg(addr_oc_thermal, 8'h00);
		// Three cycles of overcurrent must not trip
		hold(7'h20, 3);
		expect_reg(addr_serious_oc, 8'h00);
		check("switch_off_o", {7'h0, sw_off}, 8'h00);
		hold(7'h20, 4);
		expect_reg(addr_serious_oc, 8'h04);
		check("switch_off_o", {7'h0, sw_off}, 8'h01);
		hold(7'h10, 3);
		expect_reg(addr_serious_oc, 8'h04);
		hold(7'h10, 4);
		expect_reg(addr_serious_oc, 8'h14);
		check("serious_oc_o", img_sc, 8'h14);
		// Clear one flag only; shut-off stays while the other stands
		mcu.access(1'b1, addr_serious_oc, 8'h04, r);
		expect_reg(addr_serious_oc, 8'h04);
		check("switch_off_o", {7'h0, sw_off}, 8'h01);
		mcu.access(1'b1, addr_serious_oc, 8'h00, r);
		expect_reg(addr_serious_oc, 8'h00);
		check("switch_off_o", {7'h0, sw_off}, 8'h00);
		// Writing ones cannot set flags; unmapped reads give zero
		mcu.access(1'b1, addr_serious_oc, 8'hff, r);
		expect_reg(addr_serious_oc, 8'h00);
		expect_reg(8'hd8, 8'h00);
		// Every bus limit condition in both directions
		for (int m = 0; m < 2; m++) begin
			@(posedge core_clk_i);
			step_up <= m[0];
			repeat (4) @(posedge core_clk_i);
			for (int i = 0; i < 4; i++) begin
				hold(7'h08 >> i, 4);
				expect_reg(addr_bus_limit, 8'h01 << bit_of[m][i]);
				check("bus_limit_o", img_bl, 8'h01 << bit_of[m][i]);
				mcu.access(1'b1, addr_bus_limit, 8'h00, r);
				expect_reg(addr_bus_limit, 8'h00);
			end
		end
		results();
	end
endmodule : fault_status_flag_bank_tb
`default_nettype wire
